//--- logic/adc_flag_params.svh
// Register offsets, field positions and timing counts for the converter post logic
`ifndef ADC_FLAG_PARAMS_SVH
`define ADC_FLAG_PARAMS_SVH
`define OFS_OFFSET_CTRL 8'h40
`define OFS_OFFSET_VAL_LO 8'h41
`define OFS_OFFSET_VAL_HI 8'h42
`define OFS_FLAG_CTRL 8'h45
`define OFS_UPPER_LO 8'h47
`define OFS_UPPER_HI 8'h48
`define OFS_LOWER_LO 8'h49
`define OFS_LOWER_HI 8'h4a
`define OFS_DWELL_LO 8'h4b
`define OFS_DWELL_HI 8'h4c
`define OFS_ALIGN_CTRL 8'h58
`define OFS_ALIGN_MODE 8'h59
`define REG_RESET 8'h00
`define BIT_FLAG_EN 0
`define BIT_OFFSET_EN 1
`define BIT_BW_LSB 2
`define BIT_BW_MSB 5
`define BIT_FREEZE 6
`define BIT_EDGE_MODE 1
`define BIT_EDGE_FALL 0
`define BIT_NCO_EN 0
`define BIT_NCO_ONCE 1
`define BIT_DIV_EN 2
`define BIT_DIV_ONCE 3
`define BIT_FIR_EN 4
`define BIT_FIR_ONCE 5
`define BIT_ONCO_ONCE 6
`define BIT_ONCO_EN 7
`define OVER_LATENCY 7
`define BW_EXP_MAX 4'hd
`define BW_SHIFT_BASE 6'he
`define OFFSET_FRAC 27
`define THRESH_W 15
`endif

//--- logic/adc_flag_pkg.sv
// Types shared by the converter post logic
package adc_flag_pkg;
   typedef logic [7:0] reg_byte_t;
   typedef logic [7:0] reg_addr_t;
   typedef logic [13:0] sample_t;
   typedef enum logic [1:0] {
      FLAG_IDLE = 2'b00,
      FLAG_HIGH = 2'b01,
      FLAG_DWELL = 2'b11
   } flag_state_t;
endpackage : adc_flag_pkg

//--- logic/adc_threshold_dc_sync_logic.sv
// Threshold flags, overrange delay, offset correction and alignment strobe logic for two channels
// Notes on behaviour
// [RULE1] Flag stays low while magnitude is below the threshold enabled by control bit 0.
// [RULE2] Comparisons use sample magnitude only; sign is ignored.
// [RULE3] Overrange flag appears exactly seven clocks after the offending input.
// [RULE4] Flag asserts when magnitude exceeds the upper threshold register pair.
// [RULE5] Upper crossing shows on the flag four clocks after the sample.
// [RULE6] Thresholds are magnitudes where full scale equals two to the thirteenth.
// [RULE7] Flag clears only after magnitude stays below lower threshold for the dwell time.
// [RULE8] Lower threshold is fifteen bits, compared at full resolution.
// [RULE9] Dwell time is 1 to 65535 clocks from a sixteen-bit register pair.
// [RULE10] Offset correction is a high-pass loop with exponent k in control bits 5..2.
// [RULE11] Exponents 14 and 15 act as 13.
// [RULE12] Current correction reads back per channel as sixteen bits over two registers.
// [RULE13] Freeze holds and keeps applying the estimate; clearing resumes estimation.
// [RULE14] Correction is applied to output data only while enable bit 1 is set.
// [RULE15] Divider, tuning oscillator, filters and output oscillator realign once or every strobe.
// [RULE16] The alignment strobe is synchronised to the sample clock before use.
// [RULE17] The far side drives the strobe synchronous to the input clock as CMOS.
// [RULE18] Mode bit 1 picks level or edge detection; bit 0 picks rising or falling.
// [RULE19] Level and edge settings affect filters and oscillators, not the divider.
// [RULE20] Control bits 0 and 1 set tuning oscillator realignment.
// [RULE21] Control bits 4 and 5 set filter realignment.
// [RULE22] Control bits 7 and 6 set output oscillator realignment.
// [RULE23] Each channel has its own flag, dwell counter and overrange flag.
// [RULE24] Magnitude back at or above lower threshold restarts the dwell count.
// [RULE25] A write to the alignment control re-arms single-strobe realignment.
`timescale 1ns/1ps
`include "adc_flag_params.svh"
module adc_threshold_dc_sync_logic #(
   parameter int SAMPLE_W = 14
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire adc_flag_pkg::sample_t sample_chan_a,
   input wire adc_flag_pkg::sample_t sample_chan_b,
   input wire logic over_in_a,
   input wire logic over_in_b,
   input wire logic sync_in,
   input wire logic reg_write,
   input wire logic reg_chan,
   input wire adc_flag_pkg::reg_addr_t reg_addr,
   input wire adc_flag_pkg::reg_byte_t reg_wdata,
   output adc_flag_pkg::reg_byte_t reg_rdata,
   output logic threshold_flag_chan_a,
   output logic threshold_flag_chan_b,
   output logic overrange_a,
   output logic overrange_b,
   output adc_flag_pkg::sample_t data_out_a,
   output adc_flag_pkg::sample_t data_out_b,
   output logic restart_divider,
   output logic restart_nco,
   output logic restart_fir,
   output logic restart_out_nco
);
   import adc_flag_pkg::*;

   localparam int ACC_W = SAMPLE_W + `OFFSET_FRAC;
   localparam int NCH = 2;

   // Refuse widths the packed ports and magnitude compare cannot serve
   if (SAMPLE_W != $bits(sample_t)) begin : g_width_check
      $error("SAMPLE_W must match the sample port width");
   end

   // Reset release through two flip-flops
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // Per-channel views of the ports
   sample_t samp [NCH];
   logic over_in [NCH];
   logic flag_q [NCH];
   logic over_q [NCH];
   sample_t data_q [NCH];
   reg_byte_t chan_rd [NCH];
   assign samp[0] = sample_chan_a;
   assign samp[1] = sample_chan_b;
   assign over_in[0] = over_in_a;
   assign over_in[1] = over_in_b;
   assign threshold_flag_chan_a = flag_q[0];
   assign threshold_flag_chan_b = flag_q[1];
   assign overrange_a = over_q[0];
   assign overrange_b = over_q[1];
   assign data_out_a = data_q[0];
   assign data_out_b = data_q[1];

   // Magnitude of a twos complement sample
   function automatic logic [SAMPLE_W-1:0] magnitude(input logic [SAMPLE_W-1:0] s);
      magnitude = s[SAMPLE_W-1] ? SAMPLE_W'(~s + 1'b1) : s;
   endfunction : magnitude

   // Clamp the bandwidth exponent
   function automatic logic [3:0] clamp_exp(input logic [3:0] k);
      clamp_exp = (k > `BW_EXP_MAX) ? `BW_EXP_MAX : k;
   endfunction : clamp_exp

   for (genvar ch = 0; ch < NCH; ch++) begin : g_chan
      logic [7:0] offset_ctrl, next_offset_ctrl;
      logic [7:0] flag_ctrl, next_flag_ctrl;
      logic [15:0] upper_thr, next_upper_thr;
      logic [15:0] lower_thr, next_lower_thr;
      logic [15:0] dwell, next_dwell;
      logic sel;
      assign sel = reg_write && (reg_chan == 1'(ch));

      // Register writes for this channel
      always_comb begin
         next_offset_ctrl = offset_ctrl;
         next_flag_ctrl = flag_ctrl;
         next_upper_thr = upper_thr;
         next_lower_thr = lower_thr;
         next_dwell = dwell;
         if (sel) begin
            case (reg_addr)
               `OFS_OFFSET_CTRL: next_offset_ctrl = reg_wdata;
               `OFS_FLAG_CTRL: next_flag_ctrl = reg_wdata;
               `OFS_UPPER_LO: next_upper_thr[7:0] = reg_wdata;
               `OFS_UPPER_HI: next_upper_thr[15:8] = reg_wdata;
               `OFS_LOWER_LO: next_lower_thr[7:0] = reg_wdata;
               `OFS_LOWER_HI: next_lower_thr[15:8] = reg_wdata;
               `OFS_DWELL_LO: next_dwell[7:0] = reg_wdata; // [RULE9]
               `OFS_DWELL_HI: next_dwell[15:8] = reg_wdata;
               default: next_offset_ctrl = offset_ctrl;
            endcase
         end
      end

      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            offset_ctrl <= `REG_RESET;
            flag_ctrl <= `REG_RESET;
            upper_thr <= 16'h0000;
            lower_thr <= 16'h0000;
            dwell <= 16'h0000;
         end else begin
            offset_ctrl <= next_offset_ctrl;
            flag_ctrl <= next_flag_ctrl;
            upper_thr <= next_upper_thr;
            lower_thr <= next_lower_thr;
            dwell <= next_dwell;
         end
      end

      // Threshold pipeline: magnitude, compare, align, flag
      logic [SAMPLE_W-1:0] mag, next_mag;
      logic above, below, above_d, below_d;
      logic next_above, next_below;
      flag_state_t state, next_state;
      logic [15:0] cnt, next_cnt;
      logic [15:0] dwell_eff;
      logic next_flag;
      logic [`OVER_LATENCY-1:0] over_pipe, next_over_pipe;

      always_comb begin
         next_mag = magnitude(samp[ch]); // [RULE2]
         // Full-scale magnitude is 2^13; thresholds share that scale [RULE6]
         next_above = {1'b0, mag} > upper_thr[`THRESH_W-1:0]; // [RULE4]
         next_below = {1'b0, mag} < lower_thr[`THRESH_W-1:0]; // [RULE8]
         dwell_eff = (dwell == 16'h0000) ? 16'h0001 : dwell;
         next_state = state;
         next_cnt = cnt;
         case (state)
            FLAG_IDLE: begin
               next_cnt = 16'h0000;
               if (above_d) begin
                  next_state = FLAG_HIGH; // [RULE5]
               end
            end
            FLAG_HIGH, FLAG_DWELL: begin
               if (!below_d) begin
                  next_state = FLAG_HIGH; // [RULE24]
                  next_cnt = 16'h0000;
               end else if (cnt + 16'h0001 >= dwell_eff) begin
                  next_state = FLAG_IDLE; // [RULE7]
                  next_cnt = 16'h0000;
               end else begin
                  next_state = FLAG_DWELL;
                  next_cnt = cnt + 16'h0001;
               end
            end
            default: begin
               next_state = FLAG_IDLE;
               next_cnt = 16'h0000;
            end
         endcase
         if (!flag_ctrl[`BIT_FLAG_EN]) begin
            next_state = FLAG_IDLE; // [RULE1]
            next_cnt = 16'h0000;
         end
         next_flag = (next_state != FLAG_IDLE);
         next_over_pipe = {over_pipe[`OVER_LATENCY-2:0], over_in[ch]}; // [RULE3]
      end

      // Independent per-channel state [RULE23]
      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            mag <= '0;
            above <= 1'b0;
            below <= 1'b0;
            above_d <= 1'b0;
            below_d <= 1'b0;
            state <= FLAG_IDLE;
            cnt <= 16'h0000;
            flag_q[ch] <= 1'b0;
            over_pipe <= '0;
         end else begin
            mag <= next_mag;
            above <= next_above;
            below <= next_below;
            above_d <= above;
            below_d <= below;
            state <= next_state;
            cnt <= next_cnt;
            flag_q[ch] <= next_flag;
            over_pipe <= next_over_pipe;
         end
      end
      assign over_q[ch] = over_pipe[`OVER_LATENCY-1];

      // Offset estimate: first-order loop on the raw samples
      logic signed [ACC_W-1:0] acc, next_acc;
      logic signed [ACC_W:0] err;
      logic signed [ACC_W:0] step;
      logic [5:0] shift;
      logic signed [SAMPLE_W-1:0] offset_int;
      logic signed [SAMPLE_W:0] diff;
      sample_t next_data;

      always_comb begin
         shift = 6'(clamp_exp(offset_ctrl[`BIT_BW_MSB:`BIT_BW_LSB])) + `BW_SHIFT_BASE; // [RULE11]
         err = $signed({samp[ch][SAMPLE_W-1], samp[ch], {`OFFSET_FRAC{1'b0}}}) - $signed({acc[ACC_W-1], acc});
         step = err >>> shift; // [RULE10]
         next_acc = offset_ctrl[`BIT_FREEZE] ? acc : ACC_W'(acc + step[ACC_W-1:0]); // [RULE13]
         offset_int = acc[ACC_W-1 -: SAMPLE_W];
         diff = $signed({samp[ch][SAMPLE_W-1], samp[ch]}) - $signed({offset_int[SAMPLE_W-1], offset_int});
         if (diff[SAMPLE_W] != diff[SAMPLE_W-1]) begin
            next_data = diff[SAMPLE_W] ? {1'b1, {(SAMPLE_W-1){1'b0}}} : {1'b0, {(SAMPLE_W-1){1'b1}}};
         end else begin
            next_data = diff[SAMPLE_W-1:0];
         end
         if (!offset_ctrl[`BIT_OFFSET_EN]) begin
            next_data = samp[ch]; // [RULE14]
         end
      end

      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            acc <= '0;
            data_q[ch] <= '0;
         end else begin
            acc <= next_acc;
            data_q[ch] <= next_data;
         end
      end

      // Read view of this channel; estimate reads as sixteen bits [RULE12]
      always_comb begin
         case (reg_addr)
            `OFS_OFFSET_CTRL: chan_rd[ch] = offset_ctrl;
            `OFS_OFFSET_VAL_LO: chan_rd[ch] = acc[ACC_W-9 -: 8];
            `OFS_OFFSET_VAL_HI: chan_rd[ch] = acc[ACC_W-1 -: 8];
            `OFS_FLAG_CTRL: chan_rd[ch] = flag_ctrl;
            `OFS_UPPER_LO: chan_rd[ch] = upper_thr[7:0];
            `OFS_UPPER_HI: chan_rd[ch] = upper_thr[15:8];
            `OFS_LOWER_LO: chan_rd[ch] = lower_thr[7:0];
            `OFS_LOWER_HI: chan_rd[ch] = lower_thr[15:8];
            `OFS_DWELL_LO: chan_rd[ch] = dwell[7:0];
            `OFS_DWELL_HI: chan_rd[ch] = dwell[15:8];
            default: chan_rd[ch] = 8'h00;
         endcase
      end
   end

   // Alignment registers and strobe conditioning
   logic [7:0] align_ctrl, next_align_ctrl;
   logic [7:0] align_mode, next_align_mode;
   logic sync_meta, sync_q, sync_prev;
   logic ctrl_write;
   logic strobe_div, strobe_proc;
   reg_byte_t next_rdata;

   assign ctrl_write = reg_write && (reg_addr == `OFS_ALIGN_CTRL);

   always_comb begin
      next_align_ctrl = ctrl_write ? reg_wdata : align_ctrl;
      next_align_mode = (reg_write && reg_addr == `OFS_ALIGN_MODE) ? reg_wdata : align_mode;
      // Divider sees the plain level [RULE19]
      strobe_div = sync_q;
      if (align_mode[`BIT_EDGE_MODE]) begin
         strobe_proc = align_mode[`BIT_EDGE_FALL] ? (sync_prev && !sync_q) : (!sync_prev && sync_q); // [RULE18]
      end else begin
         strobe_proc = sync_q;
      end
      case (reg_addr)
         `OFS_ALIGN_CTRL: next_rdata = align_ctrl;
         `OFS_ALIGN_MODE: next_rdata = align_mode;
         default: next_rdata = chan_rd[reg_chan];
      endcase
   end

   // Two-flop synchroniser; the second stage and its one-clock delayed copy drive the strobes [RULE16]
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_meta <= 1'b0;
         sync_q <= 1'b0;
         sync_prev <= 1'b0;
         align_ctrl <= `REG_RESET;
         align_mode <= `REG_RESET;
         reg_rdata <= 8'h00;
      end else begin
         sync_meta <= sync_in;
         sync_q <= sync_meta;
         sync_prev <= sync_q;
         align_ctrl <= next_align_ctrl;
         align_mode <= next_align_mode;
         reg_rdata <= next_rdata;
      end
   end

   // Realignment per function: 0 tuning osc, 1 filters, 2 output osc, 3 divider [RULE15]
   localparam int EN_BIT [4] = '{`BIT_NCO_EN, `BIT_FIR_EN, `BIT_ONCO_EN, `BIT_DIV_EN};
   localparam int ONCE_BIT [4] = '{`BIT_NCO_ONCE, `BIT_FIR_ONCE, `BIT_ONCO_ONCE, `BIT_DIV_ONCE};
   logic [3:0] restart_q;
   assign restart_nco = restart_q[0]; // [RULE20]
   assign restart_fir = restart_q[1]; // [RULE21]
   assign restart_out_nco = restart_q[2]; // [RULE22]
   assign restart_divider = restart_q[3];

   for (genvar f = 0; f < 4; f++) begin : g_align
      logic armed, next_armed, fire, strobe;
      always_comb begin
         strobe = (f == 3) ? strobe_div : strobe_proc;
         fire = align_ctrl[EN_BIT[f]] && strobe && (!align_ctrl[ONCE_BIT[f]] || armed);
         // Write re-arms and wins over a same-cycle firing [RULE25]
         next_armed = ctrl_write ? 1'b1 : (fire && align_ctrl[ONCE_BIT[f]] ? 1'b0 : armed);
      end
      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            armed <= 1'b1;
            restart_q[f] <= 1'b0;
         end else begin
            armed <= next_armed;
            restart_q[f] <= fire;
         end
      end
   end
endmodule : adc_threshold_dc_sync_logic

//--- verification/adc_post_checker_sva.sv
// Port checker for the converter post logic
`timescale 1ns/1ps
module adc_post_checker (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire adc_flag_pkg::sample_t sample_chan_a,
   input wire adc_flag_pkg::sample_t sample_chan_b,
   input wire logic over_in_a,
   input wire logic over_in_b,
   input wire logic sync_in,
   input wire adc_flag_pkg::reg_addr_t reg_addr,
   input wire adc_flag_pkg::reg_byte_t reg_rdata,
   input wire logic threshold_flag_chan_a,
   input wire logic threshold_flag_chan_b,
   input wire logic overrange_a,
   input wire logic overrange_b,
   input wire logic restart_divider,
   input wire logic restart_nco,
   input wire logic restart_fir,
   input wire logic restart_out_nco
);
   import adc_flag_pkg::*;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);
   // Overrange follows the raw flag through the pipeline, per channel
   chk_over_delay_a: assert property (overrange_a == $past(over_in_a, 7))
      else $error("overrange a delay wrong");
   chk_over_delay_b: assert property (overrange_b == $past(over_in_b, 7))
      else $error("overrange b delay wrong");
   // A flag rise needs a nonzero sample four clocks back
   chk_flag_cause_a: assert property ($rose(threshold_flag_chan_a) |-> $past(sample_chan_a, 4) != 14'h0)
      else $error("flag a rose without cause");
   chk_flag_cause_b: assert property ($rose(threshold_flag_chan_b) |-> $past(sample_chan_b, 4) != 14'h0)
      else $error("flag b rose without cause");
   // Restart pulses only follow a synchronised strobe
   chk_div_strobe: assert property (restart_divider |-> $past(sync_in, 3))
      else $error("divider restart without strobe");
   chk_nco_strobe: assert property (restart_nco |-> $past(sync_in, 3) || $past(sync_in, 4))
      else $error("nco restart without strobe");
   chk_fir_strobe: assert property (restart_fir |-> $past(sync_in, 3) || $past(sync_in, 4))
      else $error("filter restart without strobe");
   chk_out_strobe: assert property (restart_out_nco |-> $past(sync_in, 3) || $past(sync_in, 4))
      else $error("output nco restart without strobe");
   // Unmapped addresses read as zero
   chk_unmapped_zero: assert property (!(reg_addr inside {8'h40, 8'h41, 8'h42, 8'h45, 8'h47, 8'h48, 8'h49, 8'h4a,
      8'h4b, 8'h4c, 8'h58, 8'h59}) |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   // Outputs held quiet through reset
   chk_reset_quiet: assert property (disable iff (1'b0) !reset_n && $past(!reset_n) |->
      !overrange_a && !threshold_flag_chan_a && !restart_fir && reg_rdata == 8'h00)
      else $error("outputs active in reset");
endmodule : adc_post_checker
bind adc_threshold_dc_sync_logic adc_post_checker chk (.sys_clk(sys_clk), .reset_n(reset_n),
   .sample_chan_a(sample_chan_a), .sample_chan_b(sample_chan_b), .over_in_a(over_in_a), .over_in_b(over_in_b),
   .sync_in(sync_in), .reg_addr(reg_addr), .reg_rdata(reg_rdata), .threshold_flag_chan_a(threshold_flag_chan_a),
   .threshold_flag_chan_b(threshold_flag_chan_b), .overrange_a(overrange_a), .overrange_b(overrange_b),
   .restart_divider(restart_divider), .restart_nco(restart_nco), .restart_fir(restart_fir),
   .restart_out_nco(restart_out_nco));

//--- verification/align_source.sv
// Alignment strobe source standing at the far side
`timescale 1ns/1ps
module align_source (
   input wire logic sys_clk,
   input wire logic fire,
   input wire logic [3:0] width,
   output logic sync_in
);
   logic [3:0] left = 4'h0;
   // Strobe launched on the clock edge so it stays synchronous to the sample clock
   always @(posedge sys_clk) begin
      if (fire) begin
         left <= width;
      end else if (left != 4'h0) begin
         left <= left - 4'h1;
      end
   end
   assign sync_in = (left != 4'h0);
endmodule : align_source

//--- verification/tb_top.sv
// Self-checking bench for the converter post logic
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin err_count++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top;
   import adc_flag_pkg::*;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   sample_t sample_chan_a = 14'h0;
   sample_t sample_chan_b = 14'h0;
   logic over_in_a = 1'b0;
   logic over_in_b = 1'b0;
   logic sync_in;
   logic reg_write = 1'b0;
   logic reg_chan = 1'b0;
   reg_addr_t reg_addr = 8'h0;
   reg_byte_t reg_wdata = 8'h0;
   reg_byte_t reg_rdata;
   logic threshold_flag_chan_a, threshold_flag_chan_b, overrange_a, overrange_b;
   sample_t data_out_a, data_out_b;
   logic restart_divider, restart_nco, restart_fir, restart_out_nco;
   logic fire = 1'b0;
   int err_count = 0;
   int cmp_count = 0;
   int cnt_nco, cnt_fir, cnt_out, cnt_div;
   // Clock at 20 MHz
   always #25 sys_clk = ~sys_clk;
   adc_threshold_dc_sync_logic DUT (.sys_clk(sys_clk), .reset_n(reset_n), .sample_chan_a(sample_chan_a),
      .sample_chan_b(sample_chan_b), .over_in_a(over_in_a), .over_in_b(over_in_b), .sync_in(sync_in),
      .reg_write(reg_write), .reg_chan(reg_chan), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .threshold_flag_chan_a(threshold_flag_chan_a), .threshold_flag_chan_b(threshold_flag_chan_b),
      .overrange_a(overrange_a), .overrange_b(overrange_b), .data_out_a(data_out_a), .data_out_b(data_out_b),
      .restart_divider(restart_divider), .restart_nco(restart_nco), .restart_fir(restart_fir),
      .restart_out_nco(restart_out_nco));
   align_source strobe_src (.sys_clk(sys_clk), .fire(fire), .width(4'h3), .sync_in(sync_in));
   // Count restart pulses
   always @(posedge sys_clk) begin
      cnt_nco += restart_nco;
      cnt_fir += restart_fir;
      cnt_out += restart_out_nco;
      cnt_div += restart_divider;
   end
   task automatic wr(input logic c, input reg_addr_t a, input reg_byte_t d);
      @(posedge sys_clk) begin reg_write <= 1'b1; reg_chan <= c; reg_addr <= a; reg_wdata <= d; end
      @(posedge sys_clk) reg_write <= 1'b0;
   endtask : wr
   task automatic rd(input logic c, input reg_addr_t a, output reg_byte_t v);
      @(posedge sys_clk) begin reg_chan <= c; reg_addr <= a; end
      @(posedge sys_clk) #1 v = reg_rdata;
   endtask : rd
   task automatic rd_est(output logic [15:0] e);
      reg_byte_t lo, hi;
      rd(1'b1, 8'h41, lo);
      rd(1'b1, 8'h42, hi);
      e = {hi, lo};
   endtask : rd_est
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : wrap_up
   task automatic reg_scenario;
      reg_byte_t v;
      rd(1'b0, 8'h58, v); `CHK(v, 8'h00)
      rd(1'b0, 8'h50, v); `CHK(v, 8'h00)
      wr(1'b0, 8'h47, 8'he8); wr(1'b0, 8'h48, 8'h03); wr(1'b0, 8'h49, 8'hf4); wr(1'b0, 8'h4a, 8'h01);
      wr(1'b0, 8'h4b, 8'h03); wr(1'b0, 8'h4c, 8'h00); wr(1'b0, 8'h45, 8'h01);
      rd(1'b0, 8'h45, v); `CHK(v, 8'h01)
      rd(1'b0, 8'h4a, v); `CHK(v, 8'h01)
      rd(1'b0, 8'h4b, v); `CHK(v, 8'h03)
      rd(1'b1, 8'h47, v); `CHK(v, 8'h00)
   endtask : reg_scenario
   task automatic thr_run(input sample_t v, input bit rs, input logic hi);
      @(posedge sys_clk) sample_chan_a <= v;
      @(posedge sys_clk) sample_chan_a <= 14'h0;
      @(posedge sys_clk) sample_chan_a <= rs ? 14'h1f4 : 14'h0;
      @(posedge sys_clk) sample_chan_a <= 14'h0;
      #1 `CHK(threshold_flag_chan_a, 1'b0)
      @(posedge sys_clk) #1 `CHK(threshold_flag_chan_a, hi)
      `CHK(threshold_flag_chan_b, 1'b0)
      repeat (rs ? 4 : 2) @(posedge sys_clk);
      #1 `CHK(threshold_flag_chan_a, hi)
      @(posedge sys_clk) #1 `CHK(threshold_flag_chan_a, 1'b0)
      repeat (4) @(posedge sys_clk);
   endtask : thr_run
   task automatic over_scenario;
      @(posedge sys_clk) over_in_a <= 1'b1;
      @(posedge sys_clk) begin over_in_a <= 1'b0; over_in_b <= 1'b1; end
      @(posedge sys_clk) over_in_b <= 1'b0;
      repeat (4) @(posedge sys_clk);
      #1 `CHK(overrange_a, 1'b0)
      @(posedge sys_clk) #1 `CHK(overrange_a, 1'b1)
      `CHK(overrange_b, 1'b0)
      @(posedge sys_clk) #1 `CHK(overrange_b, 1'b1)
   endtask : over_scenario
   task automatic dc_scenario;
      logic [15:0] e1, e2, e3, e4;
      wr(1'b1, 8'h40, 8'h02);
      @(posedge sys_clk) sample_chan_b <= 14'h1f40;
      repeat (200) @(posedge sys_clk);
      rd_est(e1); `CHK(e1 != 16'h0, 1'b1)
      `CHK(data_out_b !== 14'h1f40, 1'b1)
      `CHK(data_out_a, sample_chan_a)
      wr(1'b1, 8'h40, 8'h42);
      rd_est(e2);
      wr(1'b1, 8'h41, 8'hff);
      repeat (50) @(posedge sys_clk);
      rd_est(e3); `CHK(e3, e2)
      wr(1'b1, 8'h40, 8'h40);
      repeat (2) @(posedge sys_clk);
      #1 `CHK(data_out_b, 14'h1f40)
      wr(1'b1, 8'h40, 8'h3e);
      repeat (100) @(posedge sys_clk);
      rd_est(e4); `CHK(e4 - e3 < 16'h2, 1'b1)
      wr(1'b1, 8'h40, 8'h02);
      repeat (100) @(posedge sys_clk);
      rd_est(e1); `CHK(e1 > e4, 1'b1)
   endtask : dc_scenario
   task automatic sync_scenario;
      logic [31:0] tbl [5];
      int b_nco, b_fir, b_out, b_div;
      logic [15:0] got;
      tbl[0] = 32'h0231_2100;
      tbl[1] = 32'h00c4_0016;
      tbl[2] = 32'h0385_2026;
      tbl[3] = 32'h020f_1001;
      // Same one-shot setting again: only the re-arming write lets it fire once more
      tbl[4] = 32'h020f_1001;
      for (int i = 0; i < 5; i++) begin
         wr(1'b0, 8'h59, tbl[i][31:24]);
         wr(1'b0, 8'h58, tbl[i][23:16]);
         #1 b_nco = cnt_nco;
         b_fir = cnt_fir;
         b_out = cnt_out;
         b_div = cnt_div;
         repeat (2) begin
            @(posedge sys_clk) fire <= 1'b1;
            @(posedge sys_clk) fire <= 1'b0;
            repeat (8) @(posedge sys_clk);
         end
         repeat (4) @(posedge sys_clk);
         #1 got = {4'(cnt_nco - b_nco), 4'(cnt_fir - b_fir), 4'(cnt_out - b_out), 4'(cnt_div - b_div)};
         `CHK(got, tbl[i][15:0])
      end
   endtask : sync_scenario
   // Main sequence
   initial begin
      repeat (8) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      reg_scenario();
      thr_run(14'h03e9, 1'b0, 1'b1);
      thr_run(14'h3c17, 1'b0, 1'b1);
      thr_run(14'h03e9, 1'b1, 1'b1);
      thr_run(14'h03e8, 1'b0, 1'b0);
      wr(1'b0, 8'h45, 8'h00);
      thr_run(14'h03e9, 1'b0, 1'b0);
      over_scenario();
      dc_scenario();
      sync_scenario();
      wrap_up();
   end
   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_count++;
      wrap_up();
   end
endmodule : tb_top
